// ===== logic/fbou_regs.svh
// register map, field positions, opcodes and reset values of the flag and bit op unit
`ifndef FBOU_REGS_SVH
`define FBOU_REGS_SVH
`define FBOU_ADR_DEST 4'h0
`define FBOU_ADR_SRC 4'h4
`define FBOU_ADR_STATUS 4'h8
`define FBOU_ADR_CMD 4'hC
`define FBOU_BYTE 7:0
`define FBOU_SHIFT_IN 7:1
`define FBOU_SHIFT_OUT 6:0
`define FBOU_NUM_FLAGS 8
`define FBOU_NIB_HI 7:4
`define FBOU_NIB_LO 3:0
`define FBOU_MSB 7
`define FBOU_LSB 0
`define FBOU_CMD_OP 4:0
`define FBOU_CMD_BIT 10:8
`define FBOU_CMD_BUSY 16
`define FBOU_SEL_LO 0
`define FBOU_SEL_BIT 1
`define FBOU_FLAG_C 3'h0
`define FBOU_FLAG_Z 3'h1
`define FBOU_FLAG_N 3'h2
`define FBOU_FLAG_V 3'h3
`define FBOU_FLAG_S 3'h4
`define FBOU_FLAG_H 3'h5
`define FBOU_FLAG_T 3'h6
`define FBOU_FLAG_I 3'h7
`define FBOU_ONE_HOT 8'h01
`define FBOU_RST_BYTE 8'h00
`define FBOU_RST_BIT 3'h0
`define FBOU_RST_WORD 32'h0000_0000
`define FBOU_OP_ASR 5'h00
`define FBOU_OP_SWAP 5'h01
`define FBOU_OP_FLAG_BIT_SET 5'h02
`define FBOU_OP_FLAG_BIT_CLEAR 5'h03
`define FBOU_OP_STORE_BIT 5'h04
`define FBOU_OP_LOAD_BIT 5'h05
`define FBOU_OP_SET_CARRY 5'h06
`define FBOU_OP_CLEAR_CARRY 5'h07
`define FBOU_OP_SET_NEGATIVE 5'h08
`define FBOU_OP_CLEAR_NEGATIVE 5'h09
`define FBOU_OP_SET_ZERO 5'h0A
`define FBOU_OP_CLEAR_ZERO 5'h0B
`define FBOU_OP_SET_INT_ENABLE 5'h0C
`define FBOU_OP_CLEAR_INT_ENABLE 5'h0D
`define FBOU_OP_SET_SIGN 5'h0E
`define FBOU_OP_CLEAR_SIGN 5'h0F
`define FBOU_OP_SET_OVERFLOW 5'h10
`define FBOU_OP_CLEAR_OVERFLOW 5'h11
`define FBOU_OP_SET_TRANSFER 5'h12
`define FBOU_OP_CLEAR_TRANSFER 5'h13
`define FBOU_OP_SET_HALF_CARRY 5'h14
`define FBOU_OP_CLEAR_HALF_CARRY 5'h15
`define FBOU_OP_NOP 5'h1F
`endif

// ===== logic/fbou_pkg.sv
// types shared by the flag and bit op unit
`include "fbou_regs.svh"
package fbou_pkg;
    typedef logic [7:0] fbou_byte_t;
    typedef logic [31:0] fbou_word_t;
    typedef logic [3:0] fbou_adr_t;
    typedef logic [2:0] fbou_bit_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } fbou_state_t;
    typedef enum logic [4:0] {
        OP_ASR = `FBOU_OP_ASR,
        OP_SWAP = `FBOU_OP_SWAP,
        OP_FLAG_BIT_SET = `FBOU_OP_FLAG_BIT_SET,
        OP_FLAG_BIT_CLEAR = `FBOU_OP_FLAG_BIT_CLEAR,
        OP_STORE_BIT = `FBOU_OP_STORE_BIT,
        OP_LOAD_BIT = `FBOU_OP_LOAD_BIT,
        OP_SET_CARRY = `FBOU_OP_SET_CARRY,
        OP_CLEAR_CARRY = `FBOU_OP_CLEAR_CARRY,
        OP_SET_NEGATIVE = `FBOU_OP_SET_NEGATIVE,
        OP_CLEAR_NEGATIVE = `FBOU_OP_CLEAR_NEGATIVE,
        OP_SET_ZERO = `FBOU_OP_SET_ZERO,
        OP_CLEAR_ZERO = `FBOU_OP_CLEAR_ZERO,
        OP_SET_INT_ENABLE = `FBOU_OP_SET_INT_ENABLE,
        OP_CLEAR_INT_ENABLE = `FBOU_OP_CLEAR_INT_ENABLE,
        OP_SET_SIGN = `FBOU_OP_SET_SIGN,
        OP_CLEAR_SIGN = `FBOU_OP_CLEAR_SIGN,
        OP_SET_OVERFLOW = `FBOU_OP_SET_OVERFLOW,
        OP_CLEAR_OVERFLOW = `FBOU_OP_CLEAR_OVERFLOW,
        OP_SET_TRANSFER = `FBOU_OP_SET_TRANSFER,
        OP_CLEAR_TRANSFER = `FBOU_OP_CLEAR_TRANSFER,
        OP_SET_HALF_CARRY = `FBOU_OP_SET_HALF_CARRY,
        OP_CLEAR_HALF_CARRY = `FBOU_OP_CLEAR_HALF_CARRY,
        OP_NOP = `FBOU_OP_NOP
    } fbou_op_t;
endpackage : fbou_pkg

// ===== logic/fbou_dest_unit.sv
// destination register datapath: arithmetic shift, nibble swap, bit load
`timescale 1ns/10ps
`include "fbou_regs.svh"
module fbou_dest_unit (
    // operation select
    input wire fbou_pkg::fbou_op_t op,
    input wire fbou_pkg::fbou_bit_t bit_sel,
    input wire logic t_flag,
    // operand and result
    input wire fbou_pkg::fbou_byte_t dest,
    output fbou_pkg::fbou_byte_t dest_nxt,
    output logic dest_upd
);
    import fbou_pkg::*;

    // result per opcode; others leave the register alone
    always_comb begin
        dest_nxt = dest;
        dest_upd = 1'b0;
        case (op)
            OP_ASR: begin
                dest_nxt = {dest[`FBOU_MSB], dest[`FBOU_SHIFT_IN]};
                dest_upd = 1'b1;
            end
            OP_SWAP: begin
                dest_nxt = {dest[`FBOU_NIB_LO], dest[`FBOU_NIB_HI]};
                dest_upd = 1'b1;
            end
            OP_LOAD_BIT: begin
                dest_nxt[bit_sel] = t_flag;
                dest_upd = 1'b1;
            end
            default: begin
                dest_upd = 1'b0;
            end
        endcase
    end
endmodule : fbou_dest_unit

// ===== logic/fbou_wb_slave.sv
// classic wishbone slave: registered ack, registered read data, write strobes
`timescale 1ns/10ps
`include "fbou_regs.svh"
module fbou_wb_slave (
    // clock, reset, enable
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    // wishbone
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire fbou_pkg::fbou_adr_t wb_adr,
    output logic wb_ack,
    output fbou_pkg::fbou_word_t wb_dat_r,
    // core side
    input wire logic busy,
    input wire fbou_pkg::fbou_byte_t dest_val,
    input wire fbou_pkg::fbou_byte_t src_val,
    input wire fbou_pkg::fbou_byte_t status_val,
    input wire fbou_pkg::fbou_word_t cmd_val,
    output logic wr_dest,
    output logic wr_src,
    output logic wr_status,
    output logic wr_cmd
);
    import fbou_pkg::*;

    logic ack_r;
    fbou_word_t rdat_r;
    fbou_word_t rdat_nxt;
    logic wr_go;

    // read mux; unmapped addresses read zero
    always_comb begin
        case (wb_adr)
            `FBOU_ADR_DEST: rdat_nxt = {24'h000000, dest_val};
            `FBOU_ADR_SRC: rdat_nxt = {24'h000000, src_val};
            `FBOU_ADR_STATUS: rdat_nxt = {24'h000000, status_val};
            `FBOU_ADR_CMD: rdat_nxt = cmd_val;
            default: rdat_nxt = `FBOU_RST_WORD;
        endcase
    end

    // ack one cycle after the request, held off while an op executes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
            rdat_r <= `FBOU_RST_WORD;
        end else if (ce) begin
            ack_r <= wb_cyc && wb_stb && !ack_r && !busy;
            if (wb_cyc && wb_stb && !ack_r && !busy) begin
                rdat_r <= rdat_nxt;
            end
        end
    end

    // writes take effect at the edge where the master sees ack
    assign wr_go = ack_r && wb_cyc && wb_stb && wb_we && ce;
    assign wr_dest = wr_go && (wb_adr == `FBOU_ADR_DEST);
    assign wr_src = wr_go && (wb_adr == `FBOU_ADR_SRC);
    assign wr_status = wr_go && (wb_adr == `FBOU_ADR_STATUS);
    assign wr_cmd = wr_go && (wb_adr == `FBOU_ADR_CMD);
    // ack hidden while the clock enable freezes the slave, so no write is lost
    assign wb_ack = ack_r && ce;
    assign wb_dat_r = rdat_r;
endmodule : fbou_wb_slave

// ===== logic/fbou_flag_and_bit_op_unit.sv
// top of the flag and bit op unit: registers, sequencer, status flag logic
// Function
// - shift right one, flags Z C N V
// - swap nibbles, flags untouched
// - set or clear selected status bit
// - copy source bit into transfer flag
// - copy transfer flag into destination bit
// - set and clear carry flag only
// - set and clear negative flag
// - set and clear zero flag
// - set and clear interrupt enable flag
// - set and clear sign flag
// - set and clear overflow flag
// - set and clear transfer flag
// - set and clear half carry flag
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "fbou_regs.svh"
module fbou_flag_and_bit_op_unit (
    // clock, reset, enable
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    // wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire fbou_pkg::fbou_adr_t wb_adr,
    input wire logic [3:0] wb_sel,
    input wire fbou_pkg::fbou_word_t wb_dat_w,
    output logic wb_ack,
    output fbou_pkg::fbou_word_t wb_dat_r,
    // core state
    output fbou_pkg::fbou_byte_t status_register,
    output fbou_pkg::fbou_byte_t dest_reg,
    output logic busy,
    output logic op_done
);
    import fbou_pkg::*;

    fbou_state_t state_r;
    fbou_state_t state_nxt;
    fbou_op_t op_r;
    fbou_bit_t bit_r;
    fbou_byte_t dest_r;
    fbou_byte_t source_reg;
    fbou_byte_t status_r;
    fbou_byte_t status_nxt;
    fbou_byte_t dest_nxt;
    fbou_byte_t set_mask;
    fbou_byte_t clr_mask;
    fbou_byte_t asr_mask;
    fbou_byte_t asr_val;
    logic dest_upd;
    logic done_r;
    logic exec;
    logic wr_dest;
    logic wr_src;
    logic wr_status;
    logic wr_cmd;

    // one-hot mask of a status bit
    function automatic fbou_byte_t fbou_onehot(input fbou_bit_t idx);
        fbou_onehot = `FBOU_ONE_HOT << idx;
    endfunction : fbou_onehot

    assign exec = (state_r == ST_EXEC);

    // bus slave
    fbou_wb_slave u_wb (
        .clock(clock),
        .arst_n(arst_n),
        .ce(ce),
        .wb_cyc(wb_cyc),
        .wb_stb(wb_stb),
        .wb_we(wb_we),
        .wb_adr(wb_adr),
        .wb_ack(wb_ack),
        .wb_dat_r(wb_dat_r),
        .busy(exec),
        .dest_val(dest_r),
        .src_val(source_reg),
        .status_val(status_r),
        .cmd_val({15'h0000, exec, 5'h00, bit_r, 3'h0, op_r}),
        .wr_dest(wr_dest),
        .wr_src(wr_src),
        .wr_status(wr_status),
        .wr_cmd(wr_cmd)
    );

    // destination datapath
    fbou_dest_unit u_dest (
        .op(op_r),
        .bit_sel(bit_r),
        .t_flag(status_r[`FBOU_FLAG_T]),
        .dest(dest_r),
        .dest_nxt(dest_nxt),
        .dest_upd(dest_upd)
    );

    // sequencer: a command write with byte 0 selected runs the op in the following single cycle
    always_comb begin
        case (state_r)
            ST_IDLE: state_nxt = (wr_cmd && wb_sel[`FBOU_SEL_LO]) ? ST_EXEC : ST_IDLE;
            ST_EXEC: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // command fields latched on the command write
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            op_r <= OP_NOP;
            bit_r <= `FBOU_RST_BIT;
        end else if (ce && wr_cmd) begin
            if (wb_sel[`FBOU_SEL_LO]) begin
                op_r <= fbou_op_t'(wb_dat_w[`FBOU_CMD_OP]);
            end
            if (wb_sel[`FBOU_SEL_BIT]) begin
                bit_r <= wb_dat_w[`FBOU_CMD_BIT];
            end
        end
    end

    // set and clear masks per opcode
    always_comb begin
        set_mask = `FBOU_RST_BYTE;
        clr_mask = `FBOU_RST_BYTE;
        case (op_r)
            OP_FLAG_BIT_SET: set_mask = fbou_onehot(bit_r);
            OP_FLAG_BIT_CLEAR: clr_mask = fbou_onehot(bit_r);
            OP_STORE_BIT: begin
                if (source_reg[bit_r]) begin
                    set_mask = fbou_onehot(`FBOU_FLAG_T);
                end else begin
                    clr_mask = fbou_onehot(`FBOU_FLAG_T);
                end
            end
            OP_SET_CARRY: set_mask = fbou_onehot(`FBOU_FLAG_C);
            OP_CLEAR_CARRY: clr_mask = fbou_onehot(`FBOU_FLAG_C);
            OP_SET_NEGATIVE: set_mask = fbou_onehot(`FBOU_FLAG_N);
            OP_CLEAR_NEGATIVE: clr_mask = fbou_onehot(`FBOU_FLAG_N);
            OP_SET_ZERO: set_mask = fbou_onehot(`FBOU_FLAG_Z);
            OP_CLEAR_ZERO: clr_mask = fbou_onehot(`FBOU_FLAG_Z);
            OP_SET_INT_ENABLE: set_mask = fbou_onehot(`FBOU_FLAG_I);
            OP_CLEAR_INT_ENABLE: clr_mask = fbou_onehot(`FBOU_FLAG_I);
            OP_SET_SIGN: set_mask = fbou_onehot(`FBOU_FLAG_S);
            OP_CLEAR_SIGN: clr_mask = fbou_onehot(`FBOU_FLAG_S);
            OP_SET_OVERFLOW: set_mask = fbou_onehot(`FBOU_FLAG_V);
            OP_CLEAR_OVERFLOW: clr_mask = fbou_onehot(`FBOU_FLAG_V);
            OP_SET_TRANSFER: set_mask = fbou_onehot(`FBOU_FLAG_T);
            OP_CLEAR_TRANSFER: clr_mask = fbou_onehot(`FBOU_FLAG_T);
            OP_SET_HALF_CARRY: set_mask = fbou_onehot(`FBOU_FLAG_H);
            OP_CLEAR_HALF_CARRY: clr_mask = fbou_onehot(`FBOU_FLAG_H);
            default: begin
                set_mask = `FBOU_RST_BYTE;
                clr_mask = `FBOU_RST_BYTE;
            end
        endcase
    end

    // flags produced by the arithmetic shift
    always_comb begin
        asr_mask = `FBOU_RST_BYTE;
        asr_val = `FBOU_RST_BYTE;
        if (op_r == OP_ASR) begin
            asr_mask = fbou_onehot(`FBOU_FLAG_C) | fbou_onehot(`FBOU_FLAG_Z)
                | fbou_onehot(`FBOU_FLAG_N) | fbou_onehot(`FBOU_FLAG_V);
            asr_val[`FBOU_FLAG_C] = dest_r[`FBOU_LSB];
            asr_val[`FBOU_FLAG_N] = dest_r[`FBOU_MSB];
            asr_val[`FBOU_FLAG_V] = dest_r[`FBOU_MSB] ^ dest_r[`FBOU_LSB];
            asr_val[`FBOU_FLAG_Z] = (dest_nxt == `FBOU_RST_BYTE);
        end
    end

    // per-bit next status value
    for (genvar gi = 0; gi < `FBOU_NUM_FLAGS; gi++) begin : g_flag
        assign status_nxt[gi] = asr_mask[gi] ? asr_val[gi]
            : (set_mask[gi] | (status_r[gi] & ~clr_mask[gi]));
    end

    // status register: software write when idle, op result when executing
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status_r <= `FBOU_RST_BYTE;
        end else if (ce) begin
            if (exec) begin
                status_r <= status_nxt;
            end else if (wr_status && wb_sel[`FBOU_SEL_LO]) begin
                status_r <= wb_dat_w[`FBOU_BYTE];
            end
        end
    end

    // destination and source working registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dest_r <= `FBOU_RST_BYTE;
            source_reg <= `FBOU_RST_BYTE;
        end else if (ce) begin
            if (exec && dest_upd) begin
                dest_r <= dest_nxt;
            end else if (wr_dest && wb_sel[`FBOU_SEL_LO]) begin
                dest_r <= wb_dat_w[`FBOU_BYTE];
            end
            if (wr_src && wb_sel[`FBOU_SEL_LO]) begin
                source_reg <= wb_dat_w[`FBOU_BYTE];
            end
        end
    end

    // completion pulse, one cycle after the executing cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            done_r <= 1'b0;
        end else if (ce) begin
            done_r <= exec;
        end
    end

    assign status_register = status_r;
    assign dest_reg = dest_r;
    assign busy = exec;
    assign op_done = done_r;

    // checks on executed operations
    a_exec_one_cycle: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce) |=> !exec && done_r)
        else $error("operation did not finish in one cycle");
    a_asr_shift: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && op_r == OP_ASR)
        |=> dest_r[`FBOU_SHIFT_OUT] == $past(dest_r[`FBOU_SHIFT_IN]))
        else $error("shift did not move bits down");
    a_asr_sign_kept: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && op_r == OP_ASR) |=> dest_r[`FBOU_MSB] == $past(dest_r[`FBOU_MSB]))
        else $error("shift lost the top bit");
    a_asr_flags: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && op_r == OP_ASR) |=> status_r[`FBOU_FLAG_C] == $past(dest_r[`FBOU_LSB])
        && status_r[`FBOU_FLAG_N] == dest_r[`FBOU_MSB]
        && status_r[`FBOU_FLAG_V] == (status_r[`FBOU_FLAG_N] ^ status_r[`FBOU_FLAG_C])
        && status_r[`FBOU_FLAG_Z] == (dest_r == `FBOU_RST_BYTE)
        && status_r[`FBOU_NIB_HI] == $past(status_r[`FBOU_NIB_HI]))
        else $error("shift flags wrong");
    a_swap_nibbles: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && op_r == OP_SWAP) |=> $stable(status_r)
        && dest_r == {$past(dest_r[`FBOU_NIB_LO]), $past(dest_r[`FBOU_NIB_HI])})
        else $error("swap result or flags wrong");
    a_bit_set_clear: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && (op_r == OP_FLAG_BIT_SET || op_r == OP_FLAG_BIT_CLEAR))
        |=> status_r[$past(bit_r)] == ($past(op_r) == OP_FLAG_BIT_SET)
        && (status_r | fbou_onehot($past(bit_r)))
        == ($past(status_r) | fbou_onehot($past(bit_r))))
        else $error("selected status bit not forced");
    a_store_bit: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && op_r == OP_STORE_BIT)
        |=> status_r[`FBOU_FLAG_T] == $past(source_reg[bit_r])
        && (status_r | fbou_onehot(`FBOU_FLAG_T))
        == ($past(status_r) | fbou_onehot(`FBOU_FLAG_T)))
        else $error("store bit to transfer flag wrong");
    a_load_bit: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && op_r == OP_LOAD_BIT)
        |=> dest_r[$past(bit_r)] == $past(status_r[`FBOU_FLAG_T]) && $stable(status_r))
        else $error("load bit from transfer flag wrong");
    a_carry_only: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && (op_r == OP_SET_CARRY || op_r == OP_CLEAR_CARRY))
        |=> status_r[`FBOU_FLAG_C] == ($past(op_r) == OP_SET_CARRY)
        && (status_r | fbou_onehot(`FBOU_FLAG_C))
        == ($past(status_r) | fbou_onehot(`FBOU_FLAG_C)))
        else $error("carry op wrong");
    a_negative_op: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && (op_r == OP_SET_NEGATIVE || op_r == OP_CLEAR_NEGATIVE))
        |=> status_r[`FBOU_FLAG_N] == ($past(op_r) == OP_SET_NEGATIVE))
        else $error("negative op wrong");
    a_zero_op: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && (op_r == OP_SET_ZERO || op_r == OP_CLEAR_ZERO))
        |=> status_r[`FBOU_FLAG_Z] == ($past(op_r) == OP_SET_ZERO))
        else $error("zero op wrong");
    a_int_enable_op: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && (op_r == OP_SET_INT_ENABLE || op_r == OP_CLEAR_INT_ENABLE))
        |=> status_r[`FBOU_FLAG_I] == ($past(op_r) == OP_SET_INT_ENABLE))
        else $error("interrupt enable op wrong");
    a_sign_op: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && (op_r == OP_SET_SIGN || op_r == OP_CLEAR_SIGN))
        |=> status_r[`FBOU_FLAG_S] == ($past(op_r) == OP_SET_SIGN))
        else $error("sign op wrong");
    a_overflow_op: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && (op_r == OP_SET_OVERFLOW || op_r == OP_CLEAR_OVERFLOW))
        |=> status_r[`FBOU_FLAG_V] == ($past(op_r) == OP_SET_OVERFLOW))
        else $error("overflow op wrong");
    a_transfer_op: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && (op_r == OP_SET_TRANSFER || op_r == OP_CLEAR_TRANSFER))
        |=> status_r[`FBOU_FLAG_T] == ($past(op_r) == OP_SET_TRANSFER))
        else $error("transfer op wrong");
    a_half_carry_op: assert property (@(posedge clock) disable iff (!arst_n)
        (exec && ce && (op_r == OP_SET_HALF_CARRY || op_r == OP_CLEAR_HALF_CARRY))
        |=> status_r[`FBOU_FLAG_H] == ($past(op_r) == OP_SET_HALF_CARRY))
        else $error("half carry op wrong");

    // main scenarios
    c_asr_run: cover property (@(posedge clock) disable iff (!arst_n)
        exec && ce && op_r == OP_ASR && dest_r[`FBOU_MSB]);
    c_swap_run: cover property (@(posedge clock) disable iff (!arst_n)
        exec && ce && op_r == OP_SWAP);
    c_load_bit_run: cover property (@(posedge clock) disable iff (!arst_n)
        exec && ce && op_r == OP_LOAD_BIT);
    c_int_enable_run: cover property (@(posedge clock) disable iff (!arst_n)
        exec && ce && op_r == OP_SET_INT_ENABLE);
endmodule : fbou_flag_and_bit_op_unit

// ===== testbench/testbench.sv
// self-checking bench of the flag and bit op unit against a behavioural model
`timescale 1ns/10ps
`include "fbou_regs.svh"
module testbench;
    import fbou_pkg::*;
    // design ports
    logic clock;
    logic arst_n;
    logic ce;
    logic wb_cyc;
    logic wb_stb;
    logic wb_we;
    fbou_adr_t wb_adr;
    logic [3:0] wb_sel;
    fbou_word_t wb_dat_w;
    logic wb_ack;
    fbou_word_t wb_dat_r;
    fbou_byte_t status_register;
    fbou_byte_t dest_reg;
    logic busy;
    logic op_done;
    // model state: destination, status, source
    int md;
    int ms;
    int mr;
    int n_fail;
    int checks_done;
    // status bit moved by each set/clear pair, in opcode order
    int flag_pos [8] = '{0, 2, 1, 7, 4, 3, 6, 5};

    fbou_flag_and_bit_op_unit fbou_flag_and_bit_op_unit_inst (
        .clock(clock), .arst_n(arst_n), .ce(ce),
        .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r),
        .status_register(status_register), .dest_reg(dest_reg),
        .busy(busy), .op_done(op_done)
    );

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        checks_done++;
        if (seen !== expv) begin
            n_fail++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, expv);
        end
    endtask : check

    // single place where the run ends
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // one classic cycle; stall holds the clock enable low for the first four cycles
    task automatic wb_xfer(input fbou_adr_t adr, input logic we, input logic [31:0] dat,
                           input logic [3:0] sel, input logic stall, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= dat;
        wb_sel <= sel;
        if (stall) begin
            ce <= 1'b0;
        end
        do begin
            @(posedge clock);
            n++;
            if (stall && n == 4) begin
                ce <= 1'b1;
            end
        end while (wb_ack !== 1'b1 && n < 40);
        check(wb_ack, 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (stall) begin
            check(n > 4, 1'b1);
        end
    endtask : wb_xfer

    // start one operation, update the model, compare ports and command readback
    task automatic run_op(input int op, input int b);
        logic [31:0] rd;
        int c;
        int r;
        wb_xfer(`FBOU_ADR_CMD, 1'b1, (b << 8) | op, 4'hF, 1'b0, rd);
        @(posedge clock);
        check(busy, 1'b1);
        c = 0;
        while (op_done !== 1'b1 && c < 20) begin
            @(posedge clock);
            c++;
        end
        check(c, 1);
        check(busy, 1'b0);
        case (op)
            0: begin
                c = md & 1;
                r = (md >> 1) | (md & 8'h80);
                ms = (ms & 8'hF0) | c | ((r == 0) << 1) | ((r >> 7) << 2);
                ms = ms | (((r >> 7) ^ c) << 3);
                md = r;
            end
            1: md = ((md << 4) | (md >> 4)) & 8'hFF;
            2: ms = ms | (1 << b);
            3: ms = ms & ~(1 << b);
            4: ms = (ms & 8'hBF) | (((mr >> b) & 1) << 6);
            5: md = (md & ~(1 << b)) | (((ms >> 6) & 1) << b);
            default: begin
                if (op < 22) begin
                    r = 1 << flag_pos[(op - 6) / 2];
                    ms = (op % 2) ? (ms & ~r) : (ms | r);
                end
            end
        endcase
        check(dest_reg, md & 8'hFF);
        if (op < 6) begin
            check(status_register, ms & 8'hFF);
        end else if (op < 14) begin
            check(status_register, ms & 8'hFF);
        end else begin
            check(status_register, ms & 8'hFF);
        end
        wb_xfer(`FBOU_ADR_CMD, 1'b0, 32'h0, 4'hF, 1'b0, rd);
        check(rd, (b << 8) | op);
    endtask : run_op

    // main sequence
    initial begin
        logic [31:0] rd;
        arst_n = 1'b0;
        ce = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 4'h0;
        wb_sel = 4'h0;
        wb_dat_w = 32'h0;
        n_fail = 0;
        checks_done = 0;
        void'($urandom(32'h8A821F78));
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        check(status_register, 8'h00);
        check(dest_reg, 8'h00);
        // reset values of the four registers
        for (int a = 0; a < 16; a += 4) begin
            wb_xfer(a[3:0], 1'b0, 32'h0, 4'hF, 1'b0, rd);
            check(rd, (a == 12) ? 32'h1F : 32'h0);
        end
        // unmapped place: write ignored, read zero, with a clock enable stall
        wb_xfer(4'h2, 1'b1, 32'hFFFF_FFFF, 4'hF, 1'b0, rd);
        wb_xfer(4'h2, 1'b0, 32'h0, 4'hF, 1'b1, rd);
        check(rd, 32'h0);
        // command without byte 0 select starts nothing
        wb_xfer(`FBOU_ADR_CMD, 1'b1, 32'h0000_0002, 4'h2, 1'b0, rd);
        @(posedge clock);
        check(busy, 1'b0);
        for (int t = 0; t < 30; t++) begin
            md = (t == 1) ? 0 : ((t == 2) ? 1 : $urandom_range(0, 255));
            mr = $urandom_range(0, 255);
            ms = $urandom_range(0, 255);
            wb_xfer(`FBOU_ADR_DEST, 1'b1, md, 4'h1, 1'b0, rd);
            wb_xfer(`FBOU_ADR_SRC, 1'b1, mr, 4'h1, 1'b0, rd);
            wb_xfer(`FBOU_ADR_STATUS, 1'b1, ms, 4'h1, t == 3, rd);
            wb_xfer(`FBOU_ADR_STATUS, 1'b0, 32'h0, 4'hF, 1'b0, rd);
            check(rd, ms);
            for (int k = 0; k < 23; k++) begin
                run_op((k == 22) ? 31 : k, $urandom_range(0, 7));
            end
        end
        stop_test();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        stop_test();
    end
endmodule : testbench
